// >>> verilog/pmode_pkg.sv
// Package for the power-mode and power-domain controller.
// Assumes a single 40 MHz clock and software-driven control ports.
package pmode_pkg;
   // Power modes selectable by software
   typedef enum logic [2:0] {
      MODE_ACTIVE,
      MODE_IDLE,
      MODE_EXT_SLEEP,
      MODE_DEEP_SLEEP,
      MODE_HIBERNATE
   } power_mode_type;

   // Sequencer states
   typedef enum logic [2:0] {
      SEQ_RUN,
      SEQ_WAIT_WFI,
      SEQ_GATE,
      SEQ_SLEEP,
      SEQ_UNGATE
   } seq_state_type;

   // Domain vector bit positions
   localparam int DOM_AON = 0;
   localparam int DOM_SLP = 1;
   localparam int DOM_SYS = 2;
   localparam int DOM_TIM = 3;
   localparam int DOM_RAD = 4;
   localparam int NUM_DOMAINS = 5;

   // Reset values
   localparam logic [4:0] DOMAINS_RESET = 5'h1F;
   localparam logic [3:0] RET_TRIM_RESET = 4'h0;
   localparam logic [1:0] LOW_LDO_RESET = 2'h3;

   // Field codes
   localparam logic [1:0] LOW_LDO_OFF = 2'h1;
   localparam logic ONE_BIT = 1'b1;

   // Number of hibernation wake pins on port zero
   localparam int HIB_WAKE_PINS = 5;

   // Cycles between successive domain steps while gating
   localparam int STEP_CYCLES = 4;
endpackage

// >>> verilog/sync3.sv
// Three-flop synchroniser with agreement check on the last two stages.
// Assumes the input is asynchronous to ref_clk_in.
`timescale 1ns/1ps
module sync3 #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] stable_out
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] agree;

   // A bit changes only once stages two and three agree
   assign agree = ~(s2_r ^ s3_r);

   // Chain; first stage feeds only the second
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         stable_out <= '0;
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         stable_out <= (agree & s3_r) | (~agree & stable_out);
      end
   end
endmodule

// >>> verilog/power_mode_domain_control.sv
// Power-mode sequencer: domain enables, retention, wake and reset masks.
// Assumes control ports come from software registers on ref_clk_in.
// Functional notes
// - Five power modes; domain sets fixed except the timer and radio enable bits.
// - Idle: system domain on, timer and radio follow their enables.
// - Extended sleep: always-on, sleep on; timer optional; system, radio off.
// - Extended sleep wakes on pins, calendar, capture timer or link timer.
// - Deep sleep: like extended; wakes on pins, calendar or capture timer.
// - Deep sleep exit resets device; RAM retention, calendar run selectable.
// - Hibernation: only always-on powered, no clocks, RAM retention programmable.
// - Only port-zero pins one to five wake hibernation, clocklessly.
// - OTP controller, debug and radio offset registers are retained asleep.
// - Clamp supply defaults to the higher battery rail.
// - Auto-select off forces clamp supply to the high rail.
// - Masked high-rail reset still reports status, issues no reset.
// - Disabled high-rail detector: status invalid, reads zero.
// - Timer domain keeps calendar and capture timer running asleep.
`timescale 1ns/1ps
module power_mode_domain_control
   import pmode_pkg::*;
#(
   parameter int RAM_BANKS = 3
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [2:0] mode_sel_in,
   input wire logic sleep_req_in,
   input wire logic cpu_wfi_in,
   input wire logic timer_domain_en_in,
   input wire logic radio_domain_en_in,
   input wire logic [RAM_BANKS-1:0] ram_retain_in,
   input wire logic [4:0] gpio_wake_in,
   input wire logic [8:0] pin_wake_in,
   input wire logic cal_alarm_in,
   input wire logic capture_timer_in,
   input wire logic link_timer_in,
   input wire logic clamp_auto_select_off_in,
   input wire logic hi_rail_higher_in,
   input wire logic por_high_raw_in,
   input wire logic por_high_mask_in,
   input wire logic por_high_disable_in,
   input wire logic [3:0] retention_level_trim_in,
   input wire logic core_ret_reg_enable_in,
   input wire logic force_slow_clk_core_ret_in,
   input wire logic buck_sleep_enable_in,
   input wire logic [1:0] low_rail_ldo_ctrl_in,
   input wire logic buck_level_in,
   input wire logic buck_enable_in,
   input wire logic [31:0] retain_data_in,
   input wire logic [3:0] retain_idx_in,
   input wire logic retain_wr_in,
   output logic [4:0] domain_on_out,
   output logic [RAM_BANKS-1:0] ram_retain_out,
   output logic sleep_clk_run_out,
   output logic sys_clk_run_out,
   output logic wake_reset_out,
   output logic wake_event_out,
   output logic clamp_from_high_out,
   output logic por_high_status_out,
   output logic por_high_reset_out,
   output logic por_high_det_en_out,
   output logic [3:0] clamp_trim_out,
   output logic core_ret_en_out,
   output logic core_ret_slow_out,
   output logic buck_on_out,
   output logic buck_sleep_on_out,
   output logic [1:0] low_ldo_ctrl_out,
   output logic [31:0] retain_q_out,
   output logic [2:0] mode_out
);
   // Elaboration check: bank vector must fit the retain port
   if (RAM_BANKS < 1 || RAM_BANKS > 16) begin : g_bad_banks
      $error("RAM_BANKS out of range");
   end

   localparam int RET_WORDS = 16;
   localparam logic [2:0] STEP_LAST = 3'(STEP_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////
   // Synchronised pin inputs
   logic [8:0] pin_s;
   logic por_raw_s;
   logic [4:0] hib_pin_s;

   sync3 #(.WIDTH(9)) u_pin_sync (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .async_in(pin_wake_in),
      .stable_out(pin_s)
   );
   sync3 #(.WIDTH(6)) u_misc_sync (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .async_in({por_high_raw_in, gpio_wake_in}),
      .stable_out({por_raw_s, hib_pin_s})
   );

   ////////////////////////////////////////////////////////////////////
   // Mode decode and target domain sets
   seq_state_type state_r, state_nxt;
   power_mode_type mode_r;
   logic [4:0] dom_r, dom_nxt;
   logic [4:0] target;
   logic [2:0] idx_r;
   logic [2:0] step_r;
   logic any_pin, wake_ext, wake_deep, wake_hib, wake_now;
   power_mode_type req_mode;
   logic req_ok;

   assign req_mode = power_mode_type'(mode_sel_in);
   // Codes above hibernation would park the sequencer asleep with no wake set
   assign req_ok = mode_sel_in != 3'(MODE_ACTIVE) && mode_sel_in <= 3'(MODE_HIBERNATE);
   assign any_pin = |pin_s;
   assign wake_deep = any_pin | cal_alarm_in | capture_timer_in;
   assign wake_ext = wake_deep | link_timer_in;
   assign wake_hib = |hib_pin_s;

   // Wake source set depends on the mode being slept in
   assign wake_now = (mode_r == MODE_EXT_SLEEP) ? wake_ext :
                     (mode_r == MODE_DEEP_SLEEP) ? wake_deep :
                     (mode_r == MODE_HIBERNATE) ? wake_hib : 1'b0;

   // Domains powered in the sleep mode held in mode_r
   always_comb begin
      target = DOMAINS_RESET;
      case (mode_r)
         MODE_IDLE: target = {radio_domain_en_in, timer_domain_en_in, 3'h7};
         MODE_EXT_SLEEP: target = {1'b0, timer_domain_en_in, 3'h3};
         MODE_DEEP_SLEEP: target = {1'b0, timer_domain_en_in, 3'h3};
         MODE_HIBERNATE: target = 5'h01;
         default: target = DOMAINS_RESET;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer: gate one domain per step from the top, restore upward
   logic step_done;
   assign step_done = (step_r == STEP_LAST);

   always_comb begin
      state_nxt = state_r;
      dom_nxt = dom_r;
      case (state_r)
         SEQ_RUN: if (sleep_req_in && req_ok) state_nxt = SEQ_WAIT_WFI;
         SEQ_WAIT_WFI: if (cpu_wfi_in) state_nxt = SEQ_GATE;
         SEQ_GATE: begin
            if (step_done) begin
               dom_nxt[idx_r] = target[idx_r];
               if (idx_r == 3'd0) state_nxt = SEQ_SLEEP;
            end
         end
         SEQ_SLEEP: if (wake_now || mode_r == MODE_IDLE && !cpu_wfi_in) state_nxt = SEQ_UNGATE;
         SEQ_UNGATE: begin
            if (step_done) begin
               dom_nxt[idx_r] = 1'b1;
               if (idx_r == 3'(NUM_DOMAINS - 1)) state_nxt = SEQ_RUN;
            end
         end
         default: state_nxt = SEQ_RUN;
      endcase
   end

   // State, domain vector and step counters
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= SEQ_RUN;
         dom_r <= DOMAINS_RESET;
         mode_r <= MODE_ACTIVE;
         idx_r <= 3'd0;
         step_r <= 3'd0;
      end else begin
         state_r <= state_nxt;
         dom_r <= dom_nxt;
         step_r <= (state_r == SEQ_GATE || state_r == SEQ_UNGATE) && !step_done ? step_r + 3'd1 : 3'd0;
         if (state_r == SEQ_RUN && state_nxt == SEQ_WAIT_WFI) mode_r <= req_mode;
         else if (state_r == SEQ_UNGATE && state_nxt == SEQ_RUN) mode_r <= MODE_ACTIVE;
         if (state_nxt == SEQ_GATE && state_r != SEQ_GATE) idx_r <= 3'(NUM_DOMAINS - 1);
         else if (state_r == SEQ_GATE && step_done && idx_r != 3'd0) idx_r <= idx_r - 3'd1;
         else if (state_r == SEQ_SLEEP) idx_r <= 3'd0;
         else if (state_r == SEQ_UNGATE && step_done && idx_r != 3'(NUM_DOMAINS - 1)) idx_r <= idx_r + 3'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Retention store, kept in the always-on side while domains are off
   logic [31:0] ret_mem [RET_WORDS];
   logic ret_wr_ok;
   assign ret_wr_ok = retain_wr_in && dom_r[DOM_SYS];

   // Written only while its domain is up; holds through sleep
   always_ff @(posedge ref_clk_in) begin
      if (ret_wr_ok) ret_mem[retain_idx_in] <= retain_data_in;
   end

   ////////////////////////////////////////////////////////////////////
   // Supply, reset detector and regulator control outputs
   logic por_status, por_reset, leaving_deep;
   assign por_status = por_raw_s & ~por_high_disable_in;
   assign por_reset = por_status & ~por_high_mask_in;
   assign leaving_deep = state_r == SEQ_UNGATE && state_nxt == SEQ_RUN && mode_r == MODE_DEEP_SLEEP;

   // Registered outputs
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         domain_on_out <= DOMAINS_RESET;
         ram_retain_out <= '1;
         sleep_clk_run_out <= 1'b1;
         sys_clk_run_out <= 1'b1;
         wake_reset_out <= 1'b0;
         wake_event_out <= 1'b0;
         clamp_from_high_out <= 1'b0;
         por_high_status_out <= 1'b0;
         por_high_reset_out <= 1'b0;
         por_high_det_en_out <= 1'b1;
         clamp_trim_out <= RET_TRIM_RESET;
         core_ret_en_out <= 1'b0;
         core_ret_slow_out <= 1'b0;
         buck_on_out <= 1'b0;
         buck_sleep_on_out <= 1'b0;
         low_ldo_ctrl_out <= LOW_LDO_RESET;
         retain_q_out <= '0;
         mode_out <= 3'(MODE_ACTIVE);
      end else begin
         domain_on_out <= dom_r;
         // Banks off in sleep unless selected for retention
         ram_retain_out <= dom_r[DOM_SYS] ? '1 : ram_retain_in;
         sleep_clk_run_out <= dom_r[DOM_SLP];
         sys_clk_run_out <= dom_r[DOM_SYS];
         wake_reset_out <= leaving_deep;
         wake_event_out <= state_r == SEQ_SLEEP && wake_now;
         // Auto-select picks the higher rail unless forced high
         clamp_from_high_out <= clamp_auto_select_off_in ? ONE_BIT : hi_rail_higher_in;
         por_high_status_out <= por_status;
         por_high_reset_out <= por_reset;
         por_high_det_en_out <= ~por_high_disable_in;
         clamp_trim_out <= retention_level_trim_in;
         core_ret_en_out <= core_ret_reg_enable_in;
         core_ret_slow_out <= force_slow_clk_core_ret_in;
         buck_on_out <= buck_enable_in & ~buck_level_in;
         // Buck runs asleep only if software kept it on
         buck_sleep_on_out <= buck_sleep_enable_in & buck_enable_in;
         low_ldo_ctrl_out <= low_rail_ldo_ctrl_in;
         retain_q_out <= ret_mem[retain_idx_in];
         mode_out <= 3'(mode_r);
      end
   end
endmodule

// >>> verif/pmode_chk_sva.sv
// Port checker for the power-mode sequencer.
// Assumes it is bound onto power_mode_domain_control.
`timescale 1ns/1ps
module pmode_chk
   import pmode_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic cpu_wfi_in,
   input wire logic clamp_auto_select_off_in,
   input wire logic hi_rail_higher_in,
   input wire logic por_high_mask_in,
   input wire logic por_high_disable_in,
   input wire logic buck_level_in,
   input wire logic buck_enable_in,
   input wire logic [4:0] domain_on_out,
   input wire logic wake_reset_out,
   input wire logic clamp_from_high_out,
   input wire logic por_high_status_out,
   input wire logic por_high_reset_out,
   input wire logic por_high_det_en_out,
   input wire logic buck_on_out
);
   // One clock; reset cancels attempts in flight
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////
   // Domain sequencing
   AST_AON_ON: assert property (domain_on_out[DOM_AON])
      else $error("always-on domain dropped");
   AST_GATE_WFI: assert property ($fell(domain_on_out[DOM_SYS]) |-> $past(cpu_wfi_in))
      else $error("system domain gated without wfi");
   AST_GATE_ORDER: assert property ($fell(domain_on_out[DOM_SYS]) |-> !domain_on_out[DOM_RAD])
      else $error("system gated before radio");
   AST_RESTORE: assert property ($rose(domain_on_out[DOM_RAD]) |-> domain_on_out[DOM_SYS])
      else $error("radio restored before system");
   AST_WAKE_PULSE: assert property (wake_reset_out |=> !wake_reset_out)
      else $error("wake reset longer than one cycle");
   ////////////////////////////////////////////////////////////
   // Supervisor and supply selection; inputs held to cover the register stage
   AST_POR_MASK: assert property (por_high_mask_in [*3] |=> !por_high_reset_out)
      else $error("masked detector issued reset");
   AST_POR_DIS: assert property (por_high_disable_in [*3] |=> !por_high_status_out && !por_high_det_en_out)
      else $error("disabled detector still active");
   AST_CLAMP_OFF: assert property (clamp_auto_select_off_in [*2] |=> clamp_from_high_out)
      else $error("clamp not on high rail");
   AST_CLAMP_AUTO: assert property ((!clamp_auto_select_off_in && $stable(hi_rail_higher_in)) [*2]
      |=> clamp_from_high_out == $past(hi_rail_higher_in))
      else $error("clamp auto select wrong");
   AST_BUCK: assert property ((buck_enable_in && !buck_level_in) [*2] |=> buck_on_out)
      else $error("buck not on");
endmodule
bind power_mode_domain_control pmode_chk i_pmode_chk (.ref_clk_in, .rst_n_in, .cpu_wfi_in,
   .clamp_auto_select_off_in, .hi_rail_higher_in, .por_high_mask_in, .por_high_disable_in, .buck_level_in,
   .buck_enable_in, .domain_on_out, .wake_reset_out, .clamp_from_high_out, .por_high_status_out,
   .por_high_reset_out, .por_high_det_en_out, .buck_on_out);

// >>> verif/power_mode_domain_control_tb.sv
// Self-checking bench for the power-mode sequencer.
// Assumes the bench drives every port itself at 40 MHz.
`timescale 1ns/1ps
module power_mode_domain_control_tb;
   import pmode_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [2:0] mode_sel, ram_ret, rro, mo;
   logic req, wfi, tim_en, rad_en, cal, cap, lnk, aoff, hrh, raw, msk, dis, cre, fsc, bse, blv, ben, rwr;
   logic [4:0] gpio_w, dom, ed;
   logic [8:0] pin_w;
   logic [3:0] trim, ridx, ctr;
   logic [1:0] llc, llo;
   logic [31:0] rdat, rq, kept, e;
   logic slk, sck, wrst, wev, cfh, pst, prst, pden, cro, crs, bon, bso;
   int n_rst_seen = 0, n_ev_seen = 0;
   logic [31:0] seed = 32'h789F;
   logic [31:0] q_exp[$];
   int q_sel[$];
   int n_fail = 0, n_compared = 0, cyc = 0, s;
   string nm[8] = '{"domains", "por", "clamp", "fields", "retained", "clk_ram", "wake_counts", "mode"};
   power_mode_domain_control i_power_mode_domain_control (.ref_clk_in, .rst_n_in, .mode_sel_in(mode_sel),
      .sleep_req_in(req), .cpu_wfi_in(wfi), .timer_domain_en_in(tim_en), .radio_domain_en_in(rad_en),
      .ram_retain_in(ram_ret), .gpio_wake_in(gpio_w), .pin_wake_in(pin_w), .cal_alarm_in(cal),
      .capture_timer_in(cap), .link_timer_in(lnk), .clamp_auto_select_off_in(aoff), .hi_rail_higher_in(hrh),
      .por_high_raw_in(raw), .por_high_mask_in(msk), .por_high_disable_in(dis), .retention_level_trim_in(trim),
      .core_ret_reg_enable_in(cre), .force_slow_clk_core_ret_in(fsc), .buck_sleep_enable_in(bse),
      .low_rail_ldo_ctrl_in(llc), .buck_level_in(blv), .buck_enable_in(ben), .retain_data_in(rdat),
      .retain_idx_in(ridx), .retain_wr_in(rwr), .domain_on_out(dom), .ram_retain_out(rro),
      .sleep_clk_run_out(slk), .sys_clk_run_out(sck), .wake_reset_out(wrst), .wake_event_out(wev),
      .clamp_from_high_out(cfh), .por_high_status_out(pst), .por_high_reset_out(prst),
      .por_high_det_en_out(pden), .clamp_trim_out(ctr), .core_ret_en_out(cro), .core_ret_slow_out(crs),
      .buck_on_out(bon), .buck_sleep_on_out(bso), .low_ldo_ctrl_out(llo), .retain_q_out(rq), .mode_out(mo));
   ////////////////////////////////////////////////////////////
   // 40 MHz clock
   always #12.5 ref_clk_in = ~ref_clk_in;
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [31:0] probe(input int k);
      case (k)
         0: return {27'h0, dom};
         1: return {29'h0, pst, prst, pden};
         2: return {31'h0, cfh};
         3: return {22'h0, ctr, cro, crs, bon, bso, llo};
         4: return rq;
         5: return {27'h0, slk, sck, rro};
         6: return {n_ev_seen[15:0], n_rst_seen[15:0]};
         default: return {29'h0, mo};
      endcase
   endfunction
   // Expected software field word; buck only runs asleep while enabled
   function automatic logic [31:0] exp_fields();
      return {22'h0, trim, cre, fsc, ben & ~blv, bse & ben, llc};
   endfunction
   task automatic note(input int k, input logic [31:0] v);
      q_sel.push_back(k);
      q_exp.push_back(v);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   // Bounded wait; a miss still shows as a mismatch
   task automatic wait_dom(input logic [4:0] v);
      for (int i = 0; i < 300 && dom !== v; i++) @(posedge ref_clk_in);
      note(0, {27'h0, v});
   endtask
   // Bounded wait for the sequencer to report active again
   task automatic wait_active();
      for (int i = 0; i < 300 && mo !== 3'h0; i++) @(posedge ref_clk_in);
      note(7, 32'h0);
   endtask
   task results;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Watcher: compares oldest notes away from the driving edge
   always @(negedge ref_clk_in) begin
      while (q_sel.size() > 0) begin
         s = q_sel.pop_front();
         e = q_exp.pop_front();
         n_compared++;
         if (probe(s) !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm[s], e, probe(s));
         end
      end
   end
   // Pulse counters and hang guard
   always @(posedge ref_clk_in) begin
      if (wrst === 1'b1) n_rst_seen++;
      if (wev === 1'b1) n_ev_seen++;
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {mode_sel, req, wfi, ram_ret, gpio_w, pin_w, cal, cap, lnk, aoff, hrh, raw, msk, dis} = '0;
      {trim, cre, fsc, bse, blv, ben, rdat, ridx, rwr} = '0;
      {tim_en, rad_en, llc} = 4'hF;
      tick(4);
      rst_n_in <= 1'b1;
      tick(2);
      note(0, 32'h1F);
      note(1, 32'h1);
      raw <= 1'b1;
      tick(8);
      note(1, 32'h7);
      msk <= 1'b1;
      tick(8);
      note(1, 32'h5);
      dis <= 1'b1;
      tick(8);
      note(1, 32'h0);
      {raw, msk, dis} <= 3'h0;
      for (int i = 0; i < 4; i++) begin
         {aoff, hrh} <= 2'(i);
         tick(4);
         note(2, 32'(i != 0));
      end
      $display("test por and clamp done");
      // Random software fields, both low-rail codes
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         {trim, cre, fsc, bse, blv, ben} <= seed[8:0];
         llc <= {i[0], 1'b1};
         tick(4);
         note(3, exp_fields());
      end
      seed = lfsr(seed);
      kept = seed;
      {rdat, ridx, rwr} <= {seed, seed[3:0], 1'b1};
      tick(1);
      rwr <= 1'b0;
      tick(3);
      note(4, kept);
      $display("test fields done");
      // Active and invalid codes must not start a sequence
      for (int i = 0; i < 2; i++) begin
         mode_sel <= 3'(7 * i);
         req <= 1'b1;
         tick(4);
         note(7, 32'h0);
      end
      req <= 1'b0;
      tick(1);
      $display("test refused modes done");
      // Modes: idle, extended sleep, deep sleep, hibernation
      for (int m = 1; m < 5; m++) begin
         seed = lfsr(seed);
         ed = (m == 1) ? {seed[4:3], 3'h7} : (m == 4) ? 5'h01 : {1'b0, seed[3], 3'h3};
         {rad_en, tim_en, ram_ret} <= seed[4:0];
         trim <= (m == 4) ? 4'h9 : 4'hF;
         {cre, fsc, blv, ben} <= 4'hD;
         {bse, llc} <= m[0] ? 3'h3 : 3'h5;
         mode_sel <= 3'(m);
         req <= 1'b1;
         tick(1);
         req <= 1'b0;
         wfi <= 1'b1;
         // Idle keeps most domains up; give the walk time to reach sleep
         if (m == 1) tick(30);
         wait_dom(ed);
         note(7, 32'(m));
         note(3, exp_fields());
         if (m > 1) begin
            note(5, {27'h0, m != 4, 1'b0, ram_ret});
            {rdat, rwr} <= {~kept, 1'b1};
            tick(1);
            rwr <= 1'b0;
         end
         if (m > 2) begin
            lnk <= 1'b1;
            pin_w <= (m == 4) ? 9'h1FF : 9'h0;
            tick(20);
            note(0, {27'h0, ed});
         end
         case (m)
            1: wfi <= 1'b0;
            2: lnk <= 1'b1;
            3: cal <= 1'b1;
            default: gpio_w <= 5'h10;
         endcase
         wait_dom(5'h1F);
         wait_active();
         {lnk, cal, gpio_w, pin_w, wfi} <= '0;
         tick(3);
         note(6, {16'(m - 1), 16'(m >= 3)});
         note(4, kept);
         $display("test mode %0d done", m);
      end
      tick(2);
      results();
   end
endmodule
